// file: core/vgc_register_bank.sv
/*
  gain-control register bank behind the four-wire serial port, with
  the converter word selection for the variable-gain amplifier.
  assumes: all pins synchronous to clk; host drives frames of 40 bits.
*/
// What this block does
// RQ1: enable bits for oscillator, mixer, driver reset one
// RQ2: enable bit 3 drives converter, resets one
// RQ3: enable bit 4 drives bias, resets one
// RQ4: function bit 4 bypasses table, resets zero
// RQ5: function bit 7 boosts oscillator buffer bias
// RQ6: bits 9:8 multiply lines 0 to 15
// RQ7: bits 11:10 multiply lines 16 to 31
// RQ8: bits 13:12 multiply lines 32 to 47
// RQ9: top two low bits multiply lines 48 to 63
// RQ10: 11-bit direct word acts only when bypassing
// RQ11: direct all ones max gain, 36h minimum
// RQ12: host computes direct word from gain in dB
// RQ13: four signed nibbles per correction register
// RQ14: line n is n half dB, registers from 04h
// RQ15: correction scaled by quadrant multiplier before use
// RQ16: every correction nibble resets to zero
// RQ17: converter off also turns amplifier off
// RQ18: bias off removes references except mixers
// RQ19: power-up, reset pin or 80h-00h sequence resets
// RQ20: frame: 30 data, 7 address, chip 100
// RQ21: table mode adds scaled correction to base
// RQ22: last multiplier at 15:14, reserved reads zero
`timescale 1ns/10ps
module vgc_register_bank (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reset_pin_low,
  // serial port
  input wire logic serial_select_low,
  input wire logic serial_clk,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_en,
  // attenuation line from the parallel gain control
  input wire logic [5:0] attenuation_line,
  // analog section controls
  output logic osc_path_on,
  output logic mixer_bias_on,
  output logic output_driver_on,
  output logic gain_converter_on,
  output logic vga_on,
  output logic reference_bias_on,
  output logic section_refs_on,
  output logic osc_buffer_boost,
  output logic table_skip,
  // gain converter
  output logic [10:0] dac_word
);
  import vgc_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  logic [29:0] control_word;
  logic [4:0] block_enable_control;
  logic skip_bit;
  logic boost_bit;
  logic [1:0] mult_code [4];
  logic [10:0] direct_gain_word;
  logic [15:0] correction [CORR_REGS];
  logic soft_armed;
  logic port_driven;
  logic [10:0] next_dac_word;

  // ****************************************************************
  // serial frame engine
  // ****************************************************************
  logic frame_done;
  logic [39:0] rx_word;
  logic [39:0] tx_word;
  logic port_out;

  vgc_serial_port u_port (
    .clk(clk),
    .rst_n(rst_n),
    .select_low(serial_select_low),
    .serial_clk(serial_clk),
    .serial_in(serial_in),
    .serial_out(port_out),
    .tx_word(tx_word),
    .frame_begin(),
    .frame_done(frame_done),
    .rx_word(rx_word)
  );

  // ****************************************************************
  // frame decode
  // ****************************************************************
  wire [29:0] wr_data = rx_word[39:DATA_LSB]; // see RQ20
  wire [6:0] wr_addr = rx_word[DATA_LSB-1:ADDR_LSB]; // see RQ20
  wire [2:0] wr_chip = rx_word[ADDR_LSB-1:0];
  // frames for another chip address are ignored whole
  wire wr_valid = frame_done && (wr_chip == CHIP_ADDR); // see RQ20
  wire wr_control = wr_valid && (wr_addr == REG_CONTROL);
  wire wr_enable = wr_valid && (wr_addr == REG_ENABLE);
  wire wr_function = wr_valid && (wr_addr == REG_FUNCTION);
  wire wr_gain = wr_valid && (wr_addr == REG_GAIN);
  wire wr_corr = wr_valid && (wr_addr >= REG_CORR_FIRST)
                 && (wr_addr <= REG_CORR_LAST); // see RQ14
  wire [2:0] wr_corr_idx = 3'(wr_addr - REG_CORR_FIRST);

  // ****************************************************************
  // reset sources
  // ****************************************************************
  // the second write completes the sequence; any other accepted frame in
  // between, except another 80h control write, disarms it, so a stray 00h write never clears the bank
  wire soft_fire = wr_control && soft_armed
                   && (wr_data == SOFT_FIRE); // see RQ19
  wire bank_clear = !rst_n || !reset_pin_low || soft_fire; // see RQ19

  always_ff @(posedge clk) begin
    if (bank_clear) begin
      soft_armed <= 1'b0;
    end else if (wr_valid) begin
      soft_armed <= wr_control && (wr_data == SOFT_ARM); // see RQ19
    end
  end

  // ****************************************************************
  // control register: read pointer and soft reset word
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (bank_clear) begin
      control_word <= SOFT_FIRE;
    end else if (wr_control) begin
      control_word <= wr_data;
    end
  end

  // ****************************************************************
  // enable register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (bank_clear) begin
      block_enable_control <= ENABLE_RESET; // see RQ1 see RQ2 see RQ3
    end else if (wr_enable) begin
      block_enable_control <= wr_data[4:0]; // see RQ1 see RQ2 see RQ3
    end
  end

  // ****************************************************************
  // function register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (bank_clear) begin
      skip_bit <= 1'b0; // see RQ4
      boost_bit <= 1'b0; // see RQ5
    end else if (wr_function) begin
      skip_bit <= wr_data[FN_SKIP]; // see RQ4
      boost_bit <= wr_data[FN_BOOST]; // see RQ5
    end
  end

  always_ff @(posedge clk) begin
    if (bank_clear) begin
      mult_code[0] <= MULT_RESET; // see RQ6
      mult_code[1] <= MULT_RESET; // see RQ7
      mult_code[2] <= MULT_RESET; // see RQ8
      mult_code[3] <= MULT_RESET; // see RQ9
    end else if (wr_function) begin
      mult_code[0] <= wr_data[FN_MULT0 +: 2]; // see RQ6
      mult_code[1] <= wr_data[FN_MULT1 +: 2]; // see RQ7
      mult_code[2] <= wr_data[FN_MULT2 +: 2]; // see RQ8
      mult_code[3] <= wr_data[FN_MULT3 +: 2]; // see RQ9 see RQ22
    end
  end

  // ****************************************************************
  // direct gain word
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (bank_clear) begin
      direct_gain_word <= GAIN_RESET;
    end else if (wr_gain) begin
      direct_gain_word <= wr_data[10:0]; // see RQ10
    end
  end

  // ****************************************************************
  // correction registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (bank_clear) begin
      for (int i = 0; i < CORR_REGS; i++) begin
        correction[i] <= CORR_RESET; // see RQ16
      end
    end else if (wr_corr) begin
      correction[wr_corr_idx] <= wr_data[15:0]; // see RQ13
    end
  end

  // ****************************************************************
  // readback
  // ****************************************************************
  wire [6:0] rd_addr = control_word[6:0];
  wire rd_corr = (rd_addr >= REG_CORR_FIRST) && (rd_addr <= REG_CORR_LAST);
  wire [2:0] rd_corr_idx = 3'(rd_addr - REG_CORR_FIRST);
  // reserved function bits are not stored and read as zero
  wire [29:0] rd_function = {14'h0000, mult_code[3], mult_code[2],
                             mult_code[1], mult_code[0], boost_bit,
                             2'h0, skip_bit, 4'h0}; // see RQ22
  wire [29:0] rd_data =
    (rd_addr == REG_CONTROL) ? control_word :
    (rd_addr == REG_ENABLE) ? {25'h000_0000, block_enable_control} :
    (rd_addr == REG_FUNCTION) ? rd_function :
    (rd_addr == REG_GAIN) ? {19'h0_0000, direct_gain_word} :
    rd_corr ? {14'h0000, correction[rd_corr_idx]} :
    30'h0000_0000;
  // echo the queried address and the fixed chip address behind data
  assign tx_word = {rd_data, rd_addr, CHIP_ADDR};

  // ****************************************************************
  // serial output pin
  // ****************************************************************
  // released after every reset source, driven from the next accepted frame on
  always_ff @(posedge clk) begin
    if (bank_clear) begin
      port_driven <= 1'b0;
    end else if (wr_valid) begin
      port_driven <= 1'b1;
    end
  end

  assign serial_out = port_out;
  assign serial_out_en = port_driven;

  // ****************************************************************
  // section controls
  // ****************************************************************
  assign osc_path_on = block_enable_control[EN_OSC]; // see RQ1
  assign mixer_bias_on = block_enable_control[EN_MIXER]; // see RQ1
  assign output_driver_on = block_enable_control[EN_DRIVER]; // see RQ1
  assign gain_converter_on = block_enable_control[EN_CONVERTER]; // see RQ2
  assign vga_on = block_enable_control[EN_CONVERTER]; // see RQ17
  assign reference_bias_on = block_enable_control[EN_BIAS]; // see RQ3
  // mixers bias externally, so they keep working with bias off
  assign section_refs_on = block_enable_control[EN_BIAS]; // see RQ18
  assign osc_buffer_boost = boost_bit; // see RQ5
  assign table_skip = skip_bit; // see RQ4

  // ****************************************************************
  // converter word
  // ****************************************************************
  // corrections above line 27 live outside this bank and count as zero
  wire line_here = attenuation_line[5:2] < 4'(CORR_REGS); // see RQ14
  wire [15:0] line_reg = line_here ? correction[attenuation_line[4:2]]
                                   : CORR_RESET;
  wire [3:0] line_nibble = nibble_of(line_reg,
                                     attenuation_line[1:0]); // see RQ13
  wire [1:0] line_mult = mult_code[attenuation_line[5:4]]; // see RQ15
  logic [10:0] table_word;

  vgc_gain_path u_gain (
    .line(attenuation_line),
    .correction(line_nibble),
    .mult_code(line_mult),
    .word(table_word)
  );

  // the direct word needs the bypass bit; all ones gives most gain
  assign next_dac_word = skip_bit ? direct_gain_word
                                  : table_word; // see RQ10 see RQ11

  always_ff @(posedge clk) begin
    if (bank_clear) begin
      dac_word <= BASE_TABLE[0];
    end else begin
      dac_word <= next_dac_word; // see RQ4 see RQ21
    end
  end

endmodule

// file: core/vgc_pkg.sv
/*
  constants, types and helpers of the gain-control register bank.
  assumes: included in compile order ahead of every vgc_ module.
*/
package vgc_pkg;

  // ****************************************************************
  // serial frame layout
  // ****************************************************************
  localparam logic [5:0] FRAME_LEN = 6'h28;
  localparam logic [5:0] COUNT_TOP = 6'h3f;
  localparam int DATA_LSB = 10;
  localparam int ADDR_LSB = 3;
  localparam logic [2:0] CHIP_ADDR = 3'h4;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [6:0] REG_CONTROL = 7'h00;
  localparam logic [6:0] REG_ENABLE = 7'h01;
  localparam logic [6:0] REG_FUNCTION = 7'h02;
  localparam logic [6:0] REG_GAIN = 7'h03;
  localparam logic [6:0] REG_CORR_FIRST = 7'h04;
  localparam logic [6:0] REG_CORR_LAST = 7'h0a;
  localparam int CORR_REGS = 7;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int EN_OSC = 0;
  localparam int EN_MIXER = 1;
  localparam int EN_DRIVER = 2;
  localparam int EN_CONVERTER = 3;
  localparam int EN_BIAS = 4;
  localparam logic [4:0] ENABLE_RESET = 5'h1f;
  localparam int FN_SKIP = 4;
  localparam int FN_BOOST = 7;
  localparam int FN_MULT0 = 8;
  localparam int FN_MULT1 = 10;
  localparam int FN_MULT2 = 12;
  localparam int FN_MULT3 = 14;
  localparam logic [1:0] MULT_RESET = 2'h0;
  localparam logic [10:0] GAIN_RESET = 11'h000;
  localparam logic [15:0] CORR_RESET = 16'h0000;
  localparam logic [29:0] SOFT_ARM = 30'h0000_0080;
  localparam logic [29:0] SOFT_FIRE = 30'h0000_0000;

  // ****************************************************************
  // base table: round(2047 * 10^(-line/40)), lines 0 to 63
  // ****************************************************************
  localparam logic [10:0] BASE_TABLE [64] = '{
    11'h7ff, 11'h78c, 11'h720, 11'h6ba, 11'h65a, 11'h5ff, 11'h5a9, 11'h558,
    11'h50c, 11'h4c3, 11'h47f, 11'h43f, 11'h402, 11'h3c9, 11'h392, 11'h35f,
    11'h32f, 11'h301, 11'h2d6, 11'h2ae, 11'h287, 11'h263, 11'h241, 11'h221,
    11'h202, 11'h1e5, 11'h1ca, 11'h1b1, 11'h198, 11'h182, 11'h16c, 11'h158,
    11'h144, 11'h132, 11'h121, 11'h111, 11'h102, 11'h0f3, 11'h0e6, 11'h0d9,
    11'h0cd, 11'h0c1, 11'h0b6, 11'h0ac, 11'h0a3, 11'h09a, 11'h091, 11'h089,
    11'h081, 11'h07a, 11'h073, 11'h06d, 11'h067, 11'h061, 11'h05b, 11'h056,
    11'h051, 11'h04d, 11'h049, 11'h045, 11'h041, 11'h03d, 11'h03a, 11'h036
  };

  typedef enum {vgc_idle, vgc_shift} vgc_ser_state_type;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [2:0] mult_factor(input logic [1:0] code);
    mult_factor = {1'b0, code} + 3'h1;
  endfunction

  function automatic logic [3:0] nibble_of(input logic [15:0] word,
                                           input logic [1:0] pos);
    nibble_of = word[{pos, 2'b00} +: 4];
  endfunction

endpackage

// file: core/vgc_serial_port.sv
/*
  four-wire serial frame engine: shifts 40 bits in, 40 bits out.
  assumes: serial pins are synchronous to clk and the serial clock is
  at most a quarter of clk, so each level lasts two samples.
*/
`timescale 1ns/10ps
module vgc_serial_port (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial pins
  input wire logic select_low,
  input wire logic serial_clk,
  input wire logic serial_in,
  output logic serial_out,
  // frame side
  input wire logic [39:0] tx_word,
  output logic frame_begin,
  output logic frame_done,
  output logic [39:0] rx_word
);
  import vgc_pkg::*;

  vgc_ser_state_type state;
  logic sclk_prev;
  logic sel_prev;
  logic [5:0] count;
  logic [39:0] tx_shift;
  wire sclk_rise = serial_clk & ~sclk_prev;
  wire sel_fall = sel_prev & ~select_low;
  wire sel_rise = ~sel_prev & select_low;

  assign frame_begin = sel_fall;
  // a frame counts only when exactly 40 rising edges were seen
  assign frame_done = (state == vgc_shift) && sel_rise
                      && (count == FRAME_LEN); // see RQ20
  assign serial_out = tx_shift[39];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= vgc_idle;
      sclk_prev <= 1'b0;
      sel_prev <= 1'b1;
      count <= 6'h00;
      rx_word <= 40'h00_0000_0000;
      tx_shift <= 40'h00_0000_0000;
    end else begin
      sclk_prev <= serial_clk;
      sel_prev <= select_low;
      unique case (state)
        vgc_idle: begin
          if (sel_fall) begin
            state <= vgc_shift;
            count <= 6'h00;
            tx_shift <= tx_word;
          end
        end
        vgc_shift: begin
          if (sel_rise) begin
            state <= vgc_idle;
          end else if (sclk_rise) begin
            rx_word <= {rx_word[38:0], serial_in}; // see RQ20
            tx_shift <= {tx_shift[38:0], 1'b0};
            if (count != COUNT_TOP) begin
              count <= count + 6'h01;
            end
          end
        end
      endcase
    end
  end

endmodule

// file: core/vgc_gain_path.sv
/*
  corrected table word: base word plus scaled signed correction.
  assumes: purely combinational; the caller registers the result.
*/
`timescale 1ns/10ps
module vgc_gain_path (
  // selection
  input wire logic [5:0] line,
  input wire logic [3:0] correction,
  input wire logic [1:0] mult_code,
  // result
  output logic [10:0] word
);
  import vgc_pkg::*;

  logic signed [7:0] scaled;
  logic signed [12:0] sum;
  wire [2:0] factor = mult_factor(mult_code); // see RQ6

  // correction times its quadrant multiplier
  assign scaled = 8'($signed(correction) * $signed({1'b0, factor})); // see RQ15
  assign sum = $signed({2'b00, BASE_TABLE[line]}) + 13'(scaled); // see RQ21
  // clamp, so a large correction cannot wrap the converter word
  assign word = sum[12] ? 11'h000 :
                (sum[11] ? 11'h7ff : sum[10:0]);

endmodule

// file: test/vgc_register_bank_props.sv
/*
  port checker of the gain-control register bank, bound to its top.
  assumes: one clock; frames end where the sampled select rises.
*/
`timescale 1ns/10ps
module vgc_register_bank_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reset_pin_low,
  // serial port
  input wire logic serial_select_low,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_en,
  // line and controls
  input wire logic [5:0] attenuation_line,
  input wire logic osc_path_on,
  input wire logic mixer_bias_on,
  input wire logic output_driver_on,
  input wire logic gain_converter_on,
  input wire logic vga_on,
  input wire logic reference_bias_on,
  input wire logic section_refs_on,
  input wire logic osc_buffer_boost,
  input wire logic table_skip,
  input wire logic [10:0] dac_word
);
  logic [4:0] en;
  assign en = {reference_bias_on, gain_converter_on, output_driver_on,
               mixer_bias_on, osc_path_on};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_vga_follows: assert property (
    vga_on == gain_converter_on)
    else $error("amplifier enable differs from converter enable");
  a_refs_follow: assert property (
    section_refs_on == reference_bias_on)
    else $error("section references differ from bias enable");
  a_reset_values: assert property (
    $rose(rst_n) |-> en == 5'h1f &&
    !table_skip && !osc_buffer_boost && !serial_out_en)
    else $error("wrong control levels after reset");
  a_pin_reset: assert property (
    $rose(reset_pin_low) |-> en == 5'h1f &&
    !table_skip && !osc_buffer_boost && !serial_out_en)
    else $error("wrong control levels after reset pin");
  a_reset_dac: assert property (
    $rose(rst_n) && attenuation_line == 6'h00 |-> dac_word == 11'h7ff)
    else $error("converter word not line zero base after reset");
  // in direct mode the word may only move after an accepted frame
  a_skip_holds: assert property (
    (serial_select_low && table_skip)[*4] |=> $stable(dac_word))
    else $error("converter word moved in direct mode");
  a_en_rise: assert property (
    $rose(serial_out_en) |-> $past(serial_select_low))
    else $error("output enable rose inside a frame");
  a_en_fall: assert property ($fell(serial_out_en) |->
    $past(serial_select_low) || !$past(rst_n))
    else $error("output enable fell without reset");
  a_out_quiet: assert property (
    serial_select_low[*3] |=> $stable(serial_out))
    else $error("serial output moved outside a frame");
  a_regs_hold: assert property (
    $changed({en, table_skip, osc_buffer_boost}) |->
    $past(serial_select_low) || !$past(reset_pin_low) || !$past(rst_n))
    else $error("control changed without frame or reset");
endmodule

bind vgc_register_bank vgc_register_bank_props u_props (.clk, .rst_n,
  .reset_pin_low, .serial_select_low, .serial_clk, .serial_in, .serial_out,
  .serial_out_en, .attenuation_line, .osc_path_on, .mixer_bias_on,
  .output_driver_on, .gain_converter_on, .vga_on, .reference_bias_on,
  .section_refs_on, .osc_buffer_boost, .table_skip, .dac_word);

// file: test/vgc_host_model.sv
/*
  host controller model: drives four-wire frames, MSB first.
  assumes: caller enters frame() off the rising edge of clk.
*/
`timescale 1ns/10ps
module vgc_host_model (
  // clock
  input wire logic clk,
  // serial pins
  output logic select_low,
  output logic serial_clk,
  output logic serial_in,
  input wire logic serial_out
);
  initial begin
    select_low = 1'b1;
    serial_clk = 1'b0;
    serial_in = 1'b0;
  end

  // ****************************************************************
  // one frame; n below 40 sends a short frame on purpose
  // ****************************************************************
  task automatic frame(input logic [39:0] w, input int n,
                       output logic [39:0] r);
    r = 40'h00_0000_0000;
    @(posedge clk) select_low <= 1'b0;
    @(posedge clk);
    for (int i = 39; i > 39 - n; i--) begin
      @(posedge clk) serial_in <= w[i];
      serial_clk <= 1'b0;
      repeat (2) @(posedge clk);
      r[i] = serial_out;
      serial_clk <= 1'b1;
      @(posedge clk);
    end
    // clock parks low; data line released shows the inverse
    @(posedge clk) serial_clk <= 1'b0;
    @(posedge clk) select_low <= 1'b1;
    serial_in <= ~serial_in;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
endmodule

// file: test/vgc_register_bank_bench.sv
/*
  self-checking bench of the gain-control register bank.
  assumes: vgc_pkg, the design and vgc_host_model compiled first.
*/
`timescale 1ns/10ps
module vgc_register_bank_bench;
  import vgc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reset_pin_low = 1'b1;
  logic [5:0] attenuation_line = 6'h00;
  logic serial_select_low, serial_clk, serial_in, serial_out;
  logic serial_out_en, osc_path_on, mixer_bias_on, output_driver_on;
  logic gain_converter_on, vga_on, reference_bias_on, section_refs_on;
  logic osc_buffer_boost, table_skip;
  logic [10:0] dac_word;
  logic [39:0] rx;
  int error_cnt = 0;
  int n_tests = 0;
  int cycles = 0;
  localparam int LIMIT = 20000;
  // rows: write flag, address, data written, data read back
  localparam logic [67:0] ROWS [10] = '{
    {1'b0, 7'h01, 30'h0000_0000, 30'h0000_001f},
    {1'b0, 7'h02, 30'h0000_0000, 30'h0000_0000},
    {1'b0, 7'h03, 30'h0000_0000, 30'h0000_0000},
    {1'b0, 7'h0a, 30'h0000_0000, 30'h0000_0000},
    {1'b1, 7'h02, 30'h3fff_ffff, 30'h0000_ff90},
    {1'b1, 7'h03, 30'h3fff_ffff, 30'h0000_07ff},
    {1'b1, 7'h05, 30'h0000_a5c3, 30'h0000_a5c3},
    {1'b1, 7'h0a, 30'h3fff_1234, 30'h0000_1234},
    {1'b1, 7'h0b, 30'h0000_5555, 30'h0000_0000},
    {1'b1, 7'h01, 30'h3fff_ffea, 30'h0000_000a}
  };

  always #10 clk = ~clk;

  vgc_register_bank dut (.clk, .rst_n, .reset_pin_low, .serial_select_low,
    .serial_clk, .serial_in, .serial_out, .serial_out_en, .attenuation_line,
    .osc_path_on, .mixer_bias_on, .output_driver_on, .gain_converter_on,
    .vga_on, .reference_bias_on, .section_refs_on, .osc_buffer_boost,
    .table_skip, .dac_word);
  // a released output line shows the host the inverse of the last bit
  wire host_sdo = serial_out_en ? serial_out : ~serial_out;
  vgc_host_model host (.clk, .select_low(serial_select_low), .serial_clk,
    .serial_in, .serial_out(host_sdo));

  // ****************************************************************
  // checks and bus cycles
  // ****************************************************************
  task automatic report(input logic [29:0] g, input logic [29:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [29:0] d);
    host.frame({d, a, CHIP_ADDR}, 40, rx);
  endtask

  // read: select the address through register 0, then shift it out
  task automatic chk_reg(input logic [6:0] a, input logic [29:0] e);
    wr(REG_CONTROL, {23'h00_0000, a});
    host.frame({23'h00_0000, a, 7'h00, CHIP_ADDR}, 40, rx);
    report({20'h0_0000, rx[9:0]}, {20'h0_0000, a, CHIP_ADDR});
    report(rx[39:10], e);
  endtask

  task automatic chk_dac(input logic [10:0] e);
    report({19'h0_0000, dac_word}, {19'h0_0000, e});
  endtask

  task automatic chk_pins(input logic [9:0] e);
    report({20'h0_0000, serial_out_en, osc_buffer_boost, table_skip,
      section_refs_on, vga_on, reference_bias_on, gain_converter_on,
      output_driver_on, mixer_bias_on, osc_path_on}, {20'h0_0000, e});
  endtask

  task automatic set_line(input logic [5:0] v);
    @(posedge clk) attenuation_line <= v;
    repeat (2) @(negedge clk);
  endtask

  task automatic end_of_test();
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk_pins(10'h07f);
    chk_dac(11'h7ff);
    foreach (ROWS[i]) begin
      if (ROWS[i][67])
        wr(ROWS[i][66:60], ROWS[i][59:30]);
      chk_reg(ROWS[i][66:60], ROWS[i][29:0]);
    end
    chk_pins(10'h3aa);
    chk_dac(11'h7ff);
    set_line(6'h14);
    chk_dac(11'h7ff);
    wr(REG_GAIN, 30'h0000_0036);
    chk_dac(11'h036);
    // another frame between the two halves disarms the soft reset
    wr(REG_CONTROL, 30'h0000_0080);
    wr(REG_ENABLE, 30'h0000_0000);
    wr(REG_CONTROL, 30'h0000_0000);
    chk_reg(REG_ENABLE, 30'h0000_0000);
    wr(REG_CONTROL, 30'h0000_0080);
    wr(REG_CONTROL, 30'h0000_0000);
    chk_pins(10'h07f);
    chk_dac(BASE_TABLE[20]);
    chk_reg(REG_CORR_LAST, 30'h0000_0000);
    wr(REG_CORR_FIRST, 30'h0000_0087);
    wr(7'h08, 30'h0000_000f);
    for (int c = 0; c < 4; c++) begin
      wr(REG_FUNCTION, 30'h0000_0800 | (30'(c) << 8));
      set_line(6'h01);
      chk_dac(BASE_TABLE[1] - 11'(8 * (c + 1)));
    end
    set_line(6'h00);
    chk_dac(11'h7ff);
    set_line(6'h10);
    chk_dac(BASE_TABLE[16] - 11'h003);
    set_line(6'h1c);
    chk_dac(BASE_TABLE[28]);
    // wrong chip address, then one bit short: both ignored
    host.frame({30'h0000_0000, REG_ENABLE, 3'h5}, 40, rx);
    host.frame({30'h0000_0000, REG_ENABLE, CHIP_ADDR}, 39, rx);
    chk_pins(10'h27f);
    wr(REG_ENABLE, 30'h0000_0000);
    chk_pins(10'h200);
    @(posedge clk) reset_pin_low <= 1'b0;
    repeat (2) @(posedge clk);
    reset_pin_low <= 1'b1;
    @(negedge clk);
    chk_pins(10'h07f);
    chk_reg(REG_FUNCTION, 30'h0000_0000);
    end_of_test();
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      error_cnt++;
      end_of_test();
    end
  end
endmodule
